// *** hw/pta_pulse_totalizer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pta_defines.svh"

module pta_pulse_totalizer
    import pta_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        ENABLE_IN,
    input  wire logic        CYCLE_END_IN,
    input  wire logic        STORE_AND_CLEAR_IN,
    input  wire logic [15:0] CONTROL_WORD_IN,
    input  wire logic [15:0] PULSE_COUNT_IN,
    output logic             COUNT_CLEAR_OUT,
    output pta_pair_t        RUNNING_TOTAL_OUT,
    output pta_pair_t        SAVED_TOTAL_OUT,
    output logic             EXECUTION_OK_OUT,
    output logic             EXEC_DONE_OUT
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pta_state_t                state_reg;
    pta_state_t                state_next;
    pta_pair_t                 run_reg;
    pta_pair_t                 saved_reg;
    logic [`PTA_WORD_W-1:0]    count_reg;
    logic                      fault_reg;
    logic                      mode_reg;
    logic [`PTA_SUM_W-1:0]     work_low_reg;
    logic [`PTA_WORD_W-1:0]    work_high_reg;
    logic [`PTA_WORD_W-1:0]    count_sync;

    // ------------------------------------------------------------------------
    // Count bus from the pulse module crosses in through two flops
    // ------------------------------------------------------------------------
    pta_sync #(
        .WIDTH (`PTA_WORD_W)
    ) u_count_sync (
        .clk_in (SYS_CLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (PULSE_COUNT_IN),
        .q_out  (count_sync)
    );

    // ------------------------------------------------------------------------
    // Decode and arithmetic
    // ------------------------------------------------------------------------
    wire logic [`PTA_SUM_W-1:0] modulus;
    wire logic                  needs_wrap;
    wire logic [`PTA_SUM_W-1:0] add_sum;
    wire logic                  start_exec;
    wire logic                  count_negative;

    // Mode picks the low-word modulus
    assign modulus        = mode_reg ? `PTA_MOD_BIN : `PTA_MOD_DEC;
    assign needs_wrap     = (work_low_reg >= modulus);
    assign add_sum        = {1'b0, run_reg.low} + {1'b0, count_reg};
    assign start_exec     = ENABLE_IN && CYCLE_END_IN;
    // A negative integer count is treated as a fault and not accumulated
    assign count_negative = count_sync[`PTA_WORD_W-1];

    // ------------------------------------------------------------------------
    // Sequencer: fetch, add, normalise, finish; enable low aborts
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PTA_IDLE: begin
                if (start_exec) begin
                    state_next = PTA_FETCH;
                end
            end
            PTA_FETCH: begin
                state_next = PTA_ADD;
            end
            PTA_ADD: begin
                state_next = PTA_NORM;
            end
            PTA_NORM: begin
                if (!needs_wrap) begin
                    state_next = PTA_FINISH;
                end
            end
            PTA_FINISH: begin
                state_next = PTA_IDLE;
            end
            default: begin
                state_next = PTA_IDLE;
            end
        endcase
        if (!ENABLE_IN) begin
            state_next = PTA_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_reg <= PTA_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Fetch: latch count and mode, then clear the pulse module's counter
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            count_reg       <= `PTA_WORD_ZERO;
            fault_reg       <= 1'b0;
            mode_reg        <= 1'b0;
            COUNT_CLEAR_OUT <= 1'b0;
        end else begin
            COUNT_CLEAR_OUT <= (state_reg == PTA_FETCH) && ENABLE_IN;
            if (state_reg == PTA_FETCH) begin
                count_reg <= count_sync;
                fault_reg <= count_negative;
                mode_reg  <= CONTROL_WORD_IN[`PTA_CTW_MODE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Working sum: add once, then strip moduli one per cycle
    // ------------------------------------------------------------------------
    // Iterating keeps the path short; at most a handful of cycles per count
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            work_low_reg  <= `PTA_SUM_ZERO;
            work_high_reg <= `PTA_WORD_ZERO;
        end else if (state_reg == PTA_ADD) begin
            work_low_reg  <= fault_reg ? {1'b0, run_reg.low} : add_sum;
            work_high_reg <= run_reg.high;
        end else if ((state_reg == PTA_NORM) && needs_wrap) begin
            work_low_reg  <= work_low_reg - modulus;
            work_high_reg <= work_high_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Finish: commit total, or copy it out and zero it
    // ------------------------------------------------------------------------
    // The add has already landed, so a same-cycle clear keeps those pulses
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            run_reg   <= '0;
            saved_reg <= '0;
        end else if ((state_reg == PTA_FINISH) && ENABLE_IN) begin
            if (STORE_AND_CLEAR_IN) begin
                saved_reg.low  <= work_low_reg[`PTA_WORD_W-1:0];
                saved_reg.high <= work_high_reg;
                run_reg        <= '0;
            end else begin
                run_reg.low    <= work_low_reg[`PTA_WORD_W-1:0];
                run_reg.high   <= work_high_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all from flops, forced to zero while disabled
    // ------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            RUNNING_TOTAL_OUT <= '0;
            SAVED_TOTAL_OUT   <= '0;
            EXECUTION_OK_OUT  <= 1'b0;
            EXEC_DONE_OUT     <= 1'b0;
        end else if (!ENABLE_IN) begin
            RUNNING_TOTAL_OUT <= '0;
            SAVED_TOTAL_OUT   <= '0;
            EXECUTION_OK_OUT  <= 1'b0;
            EXEC_DONE_OUT     <= 1'b0;
        end else begin
            RUNNING_TOTAL_OUT <= run_reg;
            SAVED_TOTAL_OUT   <= saved_reg;
            EXEC_DONE_OUT     <= (state_reg == PTA_FINISH);
            if (state_reg == PTA_FINISH) begin
                EXECUTION_OK_OUT <= !fault_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    property p_clear_after_fetch;
        (state_reg == PTA_FETCH) && ENABLE_IN |=> COUNT_CLEAR_OUT ##1 !COUNT_CLEAR_OUT;
    endproperty
    a_clear_after_fetch: assert property (p_clear_after_fetch) else $error("count clear not one pulse");

    property p_add_count;
        (state_reg == PTA_ADD) && !fault_reg && ENABLE_IN
            |=> work_low_reg == ({1'b0, $past(run_reg.low)} + {1'b0, $past(count_reg)});
    endproperty
    a_add_count: assert property (p_add_count) else $error("count not added");

    property p_total_shown;
        ENABLE_IN && $past(ENABLE_IN) |-> RUNNING_TOTAL_OUT == $past(run_reg);
    endproperty
    a_total_shown: assert property (p_total_shown) else $error("running total not shown");

    property p_store_copy;
        (state_reg == PTA_FINISH) && ENABLE_IN && STORE_AND_CLEAR_IN
            |=> saved_reg.low == $past(work_low_reg[15:0]) && saved_reg.high == $past(work_high_reg);
    endproperty
    a_store_copy: assert property (p_store_copy) else $error("saved pair not copied");

    property p_store_zero;
        (state_reg == PTA_FINISH) && ENABLE_IN && STORE_AND_CLEAR_IN |=> run_reg == '0 ##1 RUNNING_TOTAL_OUT == '0;
    endproperty
    a_store_zero: assert property (p_store_zero) else $error("running total not zeroed");

    property p_low_in_range;
        (state_reg == PTA_FINISH) && ENABLE_IN && !STORE_AND_CLEAR_IN |=> {1'b0, run_reg.low} < modulus;
    endproperty
    a_low_in_range: assert property (p_low_in_range) else $error("low word beyond limit");

    property p_finish_bounded;
        (state_reg == PTA_ADD) |-> ##[1:8] ((state_reg == PTA_FINISH) || (state_reg == PTA_IDLE));
    endproperty
    a_finish_bounded: assert property (p_finish_bounded) else $error("wrap loop too long");

    property p_mode_taken;
        (state_reg == PTA_FETCH) |=> mode_reg == $past(CONTROL_WORD_IN[8]);
    endproperty
    a_mode_taken: assert property (p_mode_taken) else $error("mode bit not taken");

    property p_disabled_zero;
        !ENABLE_IN |=> RUNNING_TOTAL_OUT == '0 && SAVED_TOTAL_OUT == '0 && !EXECUTION_OK_OUT && state_reg == PTA_IDLE;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero) else $error("outputs not zero when disabled");

    property p_ok_after_exec;
        (state_reg == PTA_FINISH) && ENABLE_IN |=> EXECUTION_OK_OUT == !$past(fault_reg) && EXEC_DONE_OUT;
    endproperty
    a_ok_after_exec: assert property (p_ok_after_exec) else $error("execution ok wrong");

    property p_count_kept;
        (state_reg == PTA_FETCH) && ENABLE_IN && !count_negative ##1 ENABLE_IN [*3] ##0 (state_reg == PTA_FINISH)
            && STORE_AND_CLEAR_IN |=> saved_reg.low != 16'h0000 || saved_reg.high != 16'h0000
            || $past(count_reg) == 16'h0000;
    endproperty
    a_count_kept: assert property (p_count_kept) else $error("count lost on store");

    c_store: cover property ((state_reg == PTA_FINISH) && ENABLE_IN && STORE_AND_CLEAR_IN);
    c_wrap: cover property ((state_reg == PTA_NORM) && needs_wrap && mode_reg);
    c_fault: cover property ((state_reg == PTA_FINISH) && fault_reg && ENABLE_IN);
    c_abort: cover property ((state_reg == PTA_NORM) && !ENABLE_IN);

endmodule // pta_pulse_totalizer

`default_nettype wire

// *** pkg/pta_defines.svh ***
`ifndef PTA_DEFINES_SVH
`define PTA_DEFINES_SVH

// ----------------------------------------------------------------------------
// Word widths
// ----------------------------------------------------------------------------
`define PTA_WORD_W       16
`define PTA_SUM_W        17

// ----------------------------------------------------------------------------
// Control word field positions
// ----------------------------------------------------------------------------
`define PTA_CTW_MODE_BIT 8

// ----------------------------------------------------------------------------
// Low-word moduli (limit plus one) and reset values
// ----------------------------------------------------------------------------
`define PTA_MOD_BIN      17'h08000
`define PTA_MOD_DEC      17'h02710
`define PTA_WORD_ZERO    16'h0000
`define PTA_SUM_ZERO     17'h00000

`endif

// *** pkg/pta_pkg.sv ***
`default_nettype none

package pta_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [4:0] {
        PTA_IDLE   = 5'h01,
        PTA_FETCH  = 5'h02,
        PTA_ADD    = 5'h04,
        PTA_NORM   = 5'h08,
        PTA_FINISH = 5'h10
    } pta_state_t;

    // ------------------------------------------------------------------------
    // Two-word total: value = high * modulus + low
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] high;
        logic [15:0] low;
    } pta_pair_t;

endpackage : pta_pkg

`default_nettype wire

// *** hw/pta_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Two-stage synchroniser for a word from outside the clock domain
// ----------------------------------------------------------------------------
module pta_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end

endmodule // pta_sync

`default_nettype wire

// *** sim/pta_pulse_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----
// Pulse module model: per-cycle counter
// ----
module pta_pulse_source (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        pulse_in,
    input  wire logic        clear_in,
    input  wire logic        fault_in,
    output logic      [15:0] count_out
);
    logic [15:0] cnt_reg;

    // Clear wins over a pulse; the host has already latched the value
    always_ff @(posedge clk_in) begin
        if (rst_in || clear_in) begin
            cnt_reg <= 16'h0000;
        end else if (pulse_in) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    // Fault mode forces the sign bit, so the host sees a negative count
    assign count_out = fault_in ? (cnt_reg | 16'h8000) : cnt_reg;
endmodule // pta_pulse_source

`default_nettype wire

// *** sim/pta_pulse_totalizer_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module pta_pulse_totalizer_tb_top;
    import pta_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b1;
    logic        cyc = 1'b0;
    logic        sc = 1'b0;
    logic [15:0] control_word = 16'h0000;
    logic        pulse = 1'b0;
    logic        fault = 1'b0;
    logic        clr;
    logic [15:0] count;
    pta_pair_t   run_t;
    pta_pair_t   sav_t;
    logic        ok;
    logic        done;
    logic [31:0] sav_exp = 32'h00000000;
    int          exp_lo = 0;
    int          exp_hi = 0;
    int          fails = 0;
    int          cmp_count = 0;

    // 50 MHz
    always #10 clk = ~clk;

    pta_pulse_totalizer i_dut (
        .SYS_CLK_IN         (clk),
        .SYS_RST_IN         (rst),
        .ENABLE_IN          (en),
        .CYCLE_END_IN       (cyc),
        .STORE_AND_CLEAR_IN (sc),
        .CONTROL_WORD_IN    (control_word),
        .PULSE_COUNT_IN     (count),
        .COUNT_CLEAR_OUT    (clr),
        .RUNNING_TOTAL_OUT  (run_t),
        .SAVED_TOTAL_OUT    (sav_t),
        .EXECUTION_OK_OUT   (ok),
        .EXEC_DONE_OUT      (done)
    );

    pta_pulse_source i_src (
        .clk_in    (clk),
        .rst_in    (rst),
        .pulse_in  (pulse),
        .clear_in  (clr),
        .fault_in  (fault),
        .count_out (count)
    );

    // ----
    // Compare and verdict
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----
    // One control cycle: n pulses, then one execution
    // ----
    task automatic run(input int n, input logic s, input logic m, input logic f);
        int mod;
        int k;
        mod = m ? 32768 : 10000;
        @(posedge clk);
        sc <= s;
        fault <= f;
        control_word <= {7'h00, m, 8'h00};
        repeat (n) begin
            @(posedge clk);
            pulse <= 1'b1;
        end
        @(posedge clk);
        pulse <= 1'b0;
        // Count must settle through the input synchroniser first
        repeat (3) @(posedge clk);
        cyc <= 1'b1;
        @(posedge clk);
        cyc <= 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        // Done must arrive within the bound and stand for one cycle only
        chk({31'h0, done}, 32'h1);
        @(posedge clk);
        #1;
        chk({31'h0, done}, 32'h0);
        if (!f) begin
            exp_lo += n;
        end
        while (exp_lo >= mod) begin
            exp_lo -= mod;
            exp_hi++;
        end
        if (s) begin
            sav_exp = {exp_hi[15:0], exp_lo[15:0]};
            exp_lo = 0;
            exp_hi = 0;
        end
        chk(run_t, {exp_hi[15:0], exp_lo[15:0]});
        chk(sav_t, sav_exp);
        chk({31'h0, ok}, {31'h0, !f});
        chk({17'h0, count[14:0]}, 32'h0);
        $display("Test n=%0d store=%0b mode=%0b fault=%0b done", n, s, m, f);
    endtask

    // ----
    // Tests
    // ----
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(run_t, 32'h0);
        chk(sav_t, 32'h0);
        run(5, 1'b0, 1'b1, 1'b0);
        run(32765, 1'b0, 1'b1, 1'b0);
        run(9998, 1'b0, 1'b0, 1'b0);
        run(7, 1'b0, 1'b0, 1'b1);
        run(3, 1'b1, 1'b0, 1'b0);
        run(4, 1'b0, 1'b0, 1'b0);
        // Disabled block shows zero on both totals and the ok flag
        @(posedge clk);
        en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(run_t, 32'h0);
        chk(sav_t, 32'h0);
        chk({31'h0, ok}, 32'h0);
        @(posedge clk);
        en <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(run_t, {exp_hi[15:0], exp_lo[15:0]});
        $display("Test disable done");
        run(0, 1'b1, 1'b1, 1'b0);
        end_of_test();
    end

    // Whole run is about 43k cycles; cut a hang well beyond that
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule // pta_pulse_totalizer_tb_top

`default_nettype wire
